// [tb/acs_analog_model.sv]
`timescale 1ns/100ps
module acs_analog_model
(
    // Front end controls
    input wire logic [3:0] channel_select_in,
    input wire logic analog_input_disable_in,
    input wire logic [7:0] dac_code_in,
    // Pin levels for channels 2 to 5
    input wire logic [3:0][7:0] levels_in,
    // Comparator
    output logic comp_out
);
    logic [7:0] level;

    always_comb
    begin
        // Reserved channels and a disabled input read as ground
        level = 8'h00;
        if (!analog_input_disable_in && channel_select_in >= 4'h2
            && channel_select_in <= 4'h5)
            level = levels_in[2'(channel_select_in - 4'h2)];
        comp_out = (level >= dac_code_in);
    end
endmodule : acs_analog_model

// [tb/tb.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
    import acs_pkg::*;
    logic clock_in, rst_in, c1_wr, c2_wr, rd, halt, comp, dis, ladder, irq;
    logic [7:0] c1_data, c2_data, c1_q, c2_q, res, st, dac, last;
    logic [3:0] ch;
    // Pins never move, so no port traffic disturbs a run
    logic [3:0][7:0] levels = {8'h00, 8'hff, 8'h3c, 8'ha5};
    int errors, total_checks;
    int nt[8] = '{PERIODS_1248, PERIODS_1248, PERIODS_78, PERIODS_156,
        PERIODS_312, PERIODS_624, PERIODS_1248, PERIODS_1248};

    acs_sequencer dut (.clock_in(clock_in), .rst_in(rst_in),
        .ctrl_one_wr_in(c1_wr), .ctrl_one_data_in(c1_data),
        .ctrl_two_wr_in(c2_wr), .ctrl_two_data_in(c2_data),
        .result_rd_in(rd), .deep_halt_in(halt),
        .conv_control_one_out(c1_q), .conv_control_two_out(c2_q),
        .conv_result_reg_out(res), .conv_status_reg_out(st),
        .channel_select_out(ch), .analog_input_disable_out(dis),
        .ladder_connect_out(ladder), .dac_code_out(dac), .comp_in(comp),
        .conv_done_irq_out(irq));

    acs_analog_model model (.channel_select_in(ch),
        .analog_input_disable_in(dis), .dac_code_in(dac),
        .levels_in(levels), .comp_out(comp));

    initial
    begin
        clock_in = 0;
        forever #2 clock_in = ~clock_in;
    end

    task finish_test;
        $display("Checks made: %0d, errors: %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    task wr(input bit two, input logic [7:0] d);
        @(negedge clock_in);
        if (two)
        begin
            c2_wr = 1;
            c2_data = d;
        end
        else
        begin
            c1_wr = 1;
            c1_data = d;
        end
        @(negedge clock_in);
        c1_wr = 0;
        c2_wr = 0;
    endtask : wr

    // Status is looked at before the read clears the end flag
    task rd_res;
        `CHK(st[ST_END_BIT], 1'b1)
        @(negedge clock_in);
        rd = 1;
        @(negedge clock_in);
        rd = 0;
        `CHK(st[ST_END_BIT], 1'b0)
    endtask : rd_res

    // Poke re-writes the start bit in mid-conversion
    task run_conv(input logic [2:0] code, input logic [3:0] c, input bit poke);
        int n;
        logic [7:0] exp;
        exp = levels[2'(c - 4'h2)];
        wr(1, {4'h1, code, 1'b0});
        `CHK(c2_q, {4'h1, code, 1'b0})
        wr(0, {4'h8, c});
        `CHK(c1_q, {4'h8, c})
        `CHK({dis, ch}, {1'b0, c})
        @(negedge clock_in);
        `CHK(c1_q, {4'h0, c})
        `CHK(st[ST_END_BIT], 1'b0)
        `CHK(dac, SAR_FIRST)
        n = 0;
        while (st[ST_BUSY_BIT] === 1'b1 && n < 2000)
        begin
            n++;
            `CHK(res, last)
            c1_wr = poke && n == 10;
            c1_data = {4'h8, c};
            @(negedge clock_in);
        end
        `CHK(n, nt[code])
        `CHK(c1_q, {4'h0, c})
        `CHK({irq, st[ST_END_BIT], res}, {2'b11, exp})
        @(negedge clock_in);
        `CHK(irq, 1'b0)
        last = exp;
    endtask : run_conv

    task t_reset;
        `CHK({c1_q, c2_q}, {C1_RESET, C2_RESET})
        `CHK({res, st}, {RESULT_RESET, STATUS_ZERO})
        `CHK({ladder, irq}, 2'b00)
    endtask : t_reset

    // Every time code, reserved ones included, on rotating channels
    task t_codes;
        for (int k = 0; k < 8; k++)
        begin
            run_conv(3'(k), 4'(k % 4 + 2), 0);
            rd_res();
        end
    endtask : t_codes

    task t_restart;
        run_conv(TIME_78, 4'h4, 0);
        run_conv(TIME_78, 4'h5, 0);
        rd_res();
        run_conv(TIME_156, 4'h2, 1);
        rd_res();
    endtask : t_restart

    task t_halt;
        wr(1, {2'b00, 1'b1, 1'b1, TIME_312, 1'b0});
        `CHK(ladder, 1'b1)
        wr(0, 8'h83);
        repeat (20) @(negedge clock_in);
        halt = 1;
        @(negedge clock_in);
        `CHK({c1_q, c2_q}, {C1_RESET, C2_RESET})
        `CHK(st, STATUS_ZERO)
        `CHK(res, RESULT_RESET)
        `CHK(ladder, 1'b0)
        wr(0, 8'h83);
        wr(1, 8'h3f);
        `CHK({c1_q, c2_q}, {C1_RESET, C2_RESET})
        halt = 0;
        // Longer than the aborted run would have lasted
        repeat (400)
        begin
            @(negedge clock_in);
            `CHK({irq, st[ST_BUSY_BIT]}, 2'b00)
        end
        last = RESULT_RESET;
        run_conv(TIME_78, 4'h3, 0);
        rd_res();
    endtask : t_halt

    initial
    begin
        #200000;
        errors++;
        finish_test();
    end

    initial
    begin
        errors = 0;
        total_checks = 0;
        last = RESULT_RESET;
        rst_in = 1;
        c1_wr = 0;
        c2_wr = 0;
        c1_data = 8'h00;
        c2_data = 8'h00;
        rd = 0;
        halt = 0;
        repeat (3) @(negedge clock_in);
        rst_in = 0;
        t_reset();
        t_codes();
        t_restart();
        t_halt();
        finish_test();
    end
endmodule : tb

// [verilog/acs_conv_timer.sv]
`timescale 1ns/100ps
module acs_conv_timer
    import acs_pkg::*;
#(
    parameter int CNT_W = ACS_CNT_W,
    parameter int BITS = ACS_RES_W
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Control
    input wire logic run_in,
    input wire logic abort_in,
    input wire logic [CNT_W-1:0] len_in,
    // Timing events
    output logic step_out,
    output logic [2:0] step_bit_out,
    output logic done_out
);

    if (2 ** CNT_W <= PERIODS_1248 || BITS * SAR_STEP >= PERIODS_78)
    begin : g_check
        $error("acs_conv_timer: counter too narrow or too many steps");
    end

    logic [CNT_W-1:0] elapsed_q;
    logic [CNT_W-1:0] elapsed_d;
    logic [CNT_W-1:0] sar_span;

    assign sar_span = CNT_W'(BITS * SAR_STEP);

    always_comb
    begin
        elapsed_d = '0;
        if (run_in && !abort_in)
        begin
            elapsed_d = elapsed_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            elapsed_q <= '0;
        end
        else
        begin
            elapsed_q <= elapsed_d;
        end
    end

    // One trial per step window, finished well before the shortest time
    assign step_out = run_in && (elapsed_q < sar_span) &&
        (&elapsed_q[SAR_STEP_LOG-1:0]);
    assign step_bit_out = ~elapsed_q[SAR_STEP_LOG+2:SAR_STEP_LOG];
    assign done_out = run_in && (elapsed_q == len_in - CNT_W'(1));

endmodule : acs_conv_timer

// [verilog/acs_pkg.sv]
package acs_pkg;

    // Register geometry
    localparam int ACS_REG_W = 8;
    localparam int ACS_RES_W = 8;
    localparam int ACS_CNT_W = 11;

    // First control register fields
    localparam int C1_START_BIT = 7;
    localparam int C1_DISABLE_BIT = 4;
    localparam int C1_CH_LSB = 0;
    localparam int C1_CH_W = 4;

    // Second control register fields
    localparam int C2_LADDER_BIT = 5;
    localparam int C2_TIME_LSB = 1;
    localparam int C2_TIME_W = 3;
    localparam int C2_LIVE_W = 6;

    // Status register fields
    localparam int ST_END_BIT = 5;
    localparam int ST_BUSY_BIT = 4;

    // Reset values
    localparam logic [7:0] C1_RESET = 8'h10;
    localparam logic [7:0] C2_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] STATUS_ZERO = 8'h00;

    // Conversion time codes
    localparam logic [2:0] TIME_78 = 3'h2;
    localparam logic [2:0] TIME_156 = 3'h3;
    localparam logic [2:0] TIME_312 = 3'h4;
    localparam logic [2:0] TIME_624 = 3'h5;
    localparam logic [2:0] TIME_1248 = 3'h6;

    // Conversion times in high-frequency clock periods
    localparam int PERIODS_78 = 78;
    localparam int PERIODS_156 = 156;
    localparam int PERIODS_312 = 312;
    localparam int PERIODS_624 = 624;
    localparam int PERIODS_1248 = 1248;

    // Successive approximation stepping
    localparam int SAR_STEP = 8;
    localparam int SAR_STEP_LOG = 3;
    localparam logic [7:0] SAR_FIRST = 8'h80;

    typedef enum logic {ACS_IDLE, ACS_CONVERT} acs_state_t;

    // Reserved codes fall back to the longest, safest time
    function automatic logic [ACS_CNT_W-1:0] period_count(
        input logic [2:0] code);
        logic [ACS_CNT_W-1:0] n;
        n = ACS_CNT_W'(PERIODS_1248);
        case (code)
            TIME_78: n = ACS_CNT_W'(PERIODS_78);
            TIME_156: n = ACS_CNT_W'(PERIODS_156);
            TIME_312: n = ACS_CNT_W'(PERIODS_312);
            TIME_624: n = ACS_CNT_W'(PERIODS_624);
            default: n = ACS_CNT_W'(PERIODS_1248);
        endcase
        return n;
    endfunction : period_count

endpackage : acs_pkg

// [verilog/acs_sequencer.sv]
`timescale 1ns/100ps
// Behaviour
// - Start bit begins converting selected channel
// - Result, end flag, interrupt together
// - Result is unsigned 8-bit code
// - Start bit clears once conversion starts
// - Result only after selected conversion time
// - Reading result clears end flag
// - Restart clears flag, keeps old result
// - Start bit is bit 7
// - Deep halt aborts, resets control registers
// - Deep halt discards stored result
// - No automatic restart after deep halt
// - Deep halt disconnects reference ladder
// - Busy flag spans conversion, cleared by halt
// - Time codes select 78 to 1248
// - Control registers ignore writes in halt
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int CNT_W = ACS_CNT_W
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Software register access
    input wire logic ctrl_one_wr_in,
    input wire logic [7:0] ctrl_one_data_in,
    input wire logic ctrl_two_wr_in,
    input wire logic [7:0] ctrl_two_data_in,
    input wire logic result_rd_in,
    // Power mode
    input wire logic deep_halt_in,
    // Register readback
    output logic [7:0] conv_control_one_out,
    output logic [7:0] conv_control_two_out,
    output logic [7:0] conv_result_reg_out,
    output logic [7:0] conv_status_reg_out,
    // Analog front end
    output logic [3:0] channel_select_out,
    output logic analog_input_disable_out,
    output logic ladder_connect_out,
    output logic [7:0] dac_code_out,
    input wire logic comp_in,
    // Completion event
    output logic conv_done_irq_out
);

    if (CNT_W < ACS_CNT_W)
    begin : g_check
        $error("acs_sequencer: CNT_W cannot hold the longest time");
    end

    acs_state_t state_q;
    acs_state_t state_d;
    logic [7:0] ctrl_one_q;
    logic [7:0] ctrl_one_d;
    logic [7:0] ctrl_two_q;
    logic [7:0] ctrl_two_d;
    logic [CNT_W-1:0] len_q;
    logic [CNT_W-1:0] len_d;
    logic [7:0] sar_q;
    logic [7:0] sar_d;
    logic [7:0] result_q;
    logic [7:0] result_d;
    logic eoc_q;
    logic eoc_d;
    logic irq_q;
    logic irq_d;
    logic busy;
    logic start_go;
    logic tmr_step;
    logic [2:0] tmr_bit;
    logic tmr_done;
    logic done;

    assign busy = (state_q == ACS_CONVERT);
    // A pending start bit is consumed only while idle
    assign start_go = !busy && ctrl_one_q[C1_START_BIT] && !deep_halt_in;
    // Halt in the final cycle still wins over completion
    assign done = tmr_done && !deep_halt_in;

    acs_conv_timer #(
        .CNT_W(CNT_W),
        .BITS(ACS_RES_W)
    ) u_timer (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .run_in(busy),
        .abort_in(deep_halt_in),
        .len_in(len_q),
        .step_out(tmr_step),
        .step_bit_out(tmr_bit),
        .done_out(tmr_done)
    );

    // Control registers
    always_comb
    begin
        ctrl_one_d = ctrl_one_q;
        ctrl_two_d = ctrl_two_q;
        if (start_go)
        begin
            ctrl_one_d[C1_START_BIT] = 1'b0;
        end
        if (ctrl_one_wr_in)
        begin
            ctrl_one_d = ctrl_one_data_in;
            if (busy || start_go)
            begin
                ctrl_one_d[C1_START_BIT] = 1'b0;
            end
        end
        if (ctrl_two_wr_in)
        begin
            ctrl_two_d = ctrl_two_data_in;
            ctrl_two_d[ACS_REG_W-1:C2_LIVE_W] = '0;
        end
        if (deep_halt_in)
        begin
            ctrl_one_d = C1_RESET;
            ctrl_two_d = C2_RESET;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ctrl_one_q <= C1_RESET;
            ctrl_two_q <= C2_RESET;
        end
        else
        begin
            ctrl_one_q <= ctrl_one_d;
            ctrl_two_q <= ctrl_two_d;
        end
    end

    // Sequencer state
    always_comb
    begin
        state_d = state_q;
        len_d = len_q;
        case (state_q)
            ACS_IDLE:
            begin
                if (start_go)
                begin
                    state_d = ACS_CONVERT;
                    // Time is frozen so a later write cannot stretch it
                    len_d = CNT_W'(period_count(
                        ctrl_two_q[C2_TIME_LSB +: C2_TIME_W]));
                end
            end
            ACS_CONVERT:
            begin
                if (done)
                begin
                    state_d = ACS_IDLE;
                end
            end
            default:
            begin
                state_d = ACS_IDLE;
            end
        endcase
        if (deep_halt_in)
        begin
            state_d = ACS_IDLE;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_q <= ACS_IDLE;
            len_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            len_q <= len_d;
        end
    end

    // Approximation, result and end flag
    always_comb
    begin
        sar_d = sar_q;
        result_d = result_q;
        eoc_d = eoc_q;
        irq_d = 1'b0;
        if (result_rd_in)
        begin
            eoc_d = 1'b0;
        end
        if (start_go)
        begin
            eoc_d = 1'b0;
            sar_d = SAR_FIRST;
        end
        if (tmr_step)
        begin
            if (!comp_in)
            begin
                sar_d[tmr_bit] = 1'b0;
            end
            if (tmr_bit != 3'h0)
            begin
                sar_d[tmr_bit - 3'h1] = 1'b1;
            end
        end
        // Completion beats a read in the same cycle
        if (done)
        begin
            result_d = sar_q;
            eoc_d = 1'b1;
            irq_d = 1'b1;
        end
        if (deep_halt_in)
        begin
            result_d = RESULT_RESET;
            sar_d = RESULT_RESET;
            eoc_d = 1'b0;
            irq_d = 1'b0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            sar_q <= RESULT_RESET;
            result_q <= RESULT_RESET;
            eoc_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            sar_q <= sar_d;
            result_q <= result_d;
            eoc_q <= eoc_d;
            irq_q <= irq_d;
        end
    end

    // Outputs
    always_comb
    begin
        conv_status_reg_out = STATUS_ZERO;
        conv_status_reg_out[ST_END_BIT] = eoc_q;
        conv_status_reg_out[ST_BUSY_BIT] = busy;
    end

    assign conv_control_one_out = ctrl_one_q;
    assign conv_control_two_out = ctrl_two_q;
    assign conv_result_reg_out = result_q;
    assign conv_done_irq_out = irq_q;
    assign channel_select_out = ctrl_one_q[C1_CH_LSB +: C1_CH_W];
    assign analog_input_disable_out = ctrl_one_q[C1_DISABLE_BIT];
    assign dac_code_out = sar_q;
    // Ladder draws current, so it is off unless needed
    assign ladder_connect_out = !deep_halt_in &&
        (ctrl_two_q[C2_LADDER_BIT] || busy);

    // Checks
    logic [CNT_W-1:0] busy_cnt_q;

    always_ff @(posedge clock_in)
    begin
        if (rst_in || !busy)
        begin
            busy_cnt_q <= '0;
        end
        else
        begin
            busy_cnt_q <= busy_cnt_q + CNT_W'(1);
        end
    end

    default clocking acs_cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    sequence halt_entry;
        deep_halt_in;
    endsequence

    sequence halted_regs;
        !busy && !eoc_q && (ctrl_one_q == C1_RESET) &&
            (ctrl_two_q == C2_RESET) && (result_q == RESULT_RESET);
    endsequence

    start_begins_a: assert property (
        start_go |=> busy && (len_q == CNT_W'(period_count(
            $past(ctrl_two_q[C2_TIME_LSB +: C2_TIME_W])))))
        else $error("Start did not begin a conversion");

    start_clears_a: assert property (
        start_go |=> !ctrl_one_q[C1_START_BIT])
        else $error("Start bit did not clear");

    done_together_a: assert property (
        $rose(eoc_q) |-> irq_q && $fell(busy) &&
            (result_q == $past(sar_q)))
        else $error("Completion outputs not simultaneous");

    conv_time_a: assert property (
        $fell(busy) && !$past(deep_halt_in) |->
            ($past(busy_cnt_q) == len_q - CNT_W'(1)))
        else $error("Conversion length differs from selected time");

    time_code_a: assert property (
        start_go && (ctrl_two_q[C2_TIME_LSB +: C2_TIME_W] == TIME_78)
            |=> len_q == CNT_W'(PERIODS_78))
        else $error("Shortest time code mismapped");

    read_clear_a: assert property (
        result_rd_in && !done |=> !eoc_q)
        else $error("Result read left end flag set");

    restart_keep_a: assert property (
        start_go |=> !eoc_q && $stable(result_q) [*2])
        else $error("Restart disturbed old result or flag");

    halt_init_a: assert property (
        halt_entry |=> halted_regs)
        else $error("Deep halt did not reinitialise");

    halt_ladder_a: assert property (
        halt_entry |-> !ladder_connect_out ##1 !ladder_connect_out)
        else $error("Ladder connected during deep halt");

    halt_writes_a: assert property (
        halt_entry and (ctrl_one_wr_in || ctrl_two_wr_in) |=>
            ctrl_one_q == C1_RESET && ctrl_two_q == C2_RESET)
        else $error("Write accepted during deep halt");

    no_resume_a: assert property (
        $fell(deep_halt_in) |-> !busy ##1 !busy)
        else $error("Conversion resumed after deep halt");

    busy_ignore_a: assert property (
        busy && ctrl_one_wr_in && ctrl_one_data_in[C1_START_BIT] |=>
            !ctrl_one_q[C1_START_BIT] && $stable(len_q))
        else $error("Start accepted while busy");

endmodule : acs_sequencer
